// ---- logic/reset_window_watchdog.sv ----
// Power-on reset sequencer and window watchdog on one system clock
// Notes on behaviour
// - Both channels' reset timeouts come from one shared reset-timebase tick.
// - Reset timeout is 64 reset-timebase ticks, same for both channels.
// - Regulation-good starts the reset timebase; timeout later that reset releases.
// - Resets and fault output only pull low or release, never drive high.
// - Watchdog timebase runs only after both resets are released.
// - After release, ignore kicks for 33 watchdog-timebase ticks.
// - After the delay, only falling kick edges are watched.
// - Kick edges under 4 ticks apart cause one reset-timeout fault pulse.
// - No kick edge within 64 ticks causes a fault pulse at expiry.
// - A kick inside the window restarts the watchdog count from zero.
// - Good kicks keep reset timebase stopped and fault output released.
// - After a fault pulse, a new delay period starts.
// - Enable input high disables the watchdog, no new fault pulses; a fault pulse already running completes.
// - All-regulated output goes low only when both channels regulate.
`timescale 1ns/1ps
module reset_window_watchdog
   import rww_pkg::*;
#(
   parameter int unsigned RESET_TB_DIV = RESET_TB_DIV_DEFAULT,
   parameter int unsigned WATCHDOG_TB_DIV = WATCHDOG_TB_DIV_DEFAULT
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire rww_pkg::pin_in_t pins_in,
   output rww_pkg::pin_out_t pins_out,
   output logic hv_reset_n,
   output logic lv_reset_n,
   output logic watchdog_fault_n
);
   import rww_pkg::*;

   localparam int DIVW = 16;

   logic rst_meta_r;
   logic rst_sync_r;
   logic [SYNC_STAGES-1:0] hv_good_sync_r;
   logic [SYNC_STAGES-1:0] lv_good_sync_r;
   logic [SYNC_STAGES-1:0] kick_sync_r;
   logic [SYNC_STAGES-1:0] wde_sync_r;
   logic hv_good_r;
   logic lv_good_r;
   logic kick_r;
   logic wd_disable_r;
   logic kick_fall;
   logic [DIVW-1:0] rtb_div_r;
   logic [DIVW-1:0] wtb_div_r;
   logic rtb_tick;
   logic wtb_tick;
   logic rtb_run;
   logic wtb_run;
   logic [6:0] hv_cnt_r;
   logic [6:0] lv_cnt_r;
   logic hv_rel_r;
   logic lv_rel_r;
   logic [6:0] wd_cnt_r;
   logic [6:0] fault_cnt_r;
   wd_state_t wd_state_r;
   logic hv_oe_r;
   logic lv_oe_r;
   logic fault_oe_r;
   logic all_reg_n_r;
   logic hv_pin_r;
   logic lv_pin_r;
   logic fault_pin_r;

   // Reset release through two flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Pin synchronisers; a change counts when stages two and three agree
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         hv_good_sync_r <= '0;
         hv_good_r <= 1'b0;
      end else begin
         hv_good_sync_r <= {hv_good_sync_r[SYNC_STAGES-2:0], pins_in.hv_regulation_good};
         if (hv_good_sync_r[1] == hv_good_sync_r[2]) begin
            hv_good_r <= hv_good_sync_r[2];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         lv_good_sync_r <= '0;
         lv_good_r <= 1'b0;
      end else begin
         lv_good_sync_r <= {lv_good_sync_r[SYNC_STAGES-2:0], pins_in.lv_regulation_good};
         if (lv_good_sync_r[1] == lv_good_sync_r[2]) begin
            lv_good_r <= lv_good_sync_r[2];
         end
      end
   end

   // Kick idles high after reset so no false falling edge follows it
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         kick_sync_r <= '1;
         kick_r <= 1'b1;
      end else begin
         kick_sync_r <= {kick_sync_r[SYNC_STAGES-2:0], pins_in.watchdog_kick};
         if (kick_sync_r[1] == kick_sync_r[2]) begin
            kick_r <= kick_sync_r[2];
         end
      end
   end

   // Disabled until the enable pin is seen low
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         wde_sync_r <= '1;
         wd_disable_r <= 1'b1;
      end else begin
         wde_sync_r <= {wde_sync_r[SYNC_STAGES-2:0], pins_in.watchdog_enable_n};
         if (wde_sync_r[1] == wde_sync_r[2]) begin
            wd_disable_r <= wde_sync_r[2];
         end
      end
   end

   // Falling edges only; level changes upward are not events
   assign kick_fall = kick_r && (kick_sync_r[1] == kick_sync_r[2]) && !kick_sync_r[2];

   // Shared reset timebase runs while a channel times out or a fault pulse lasts
   assign rtb_run = (hv_good_r && !hv_rel_r) || (lv_good_r && !lv_rel_r)
      || (wd_state_r == WD_FAULT);
   assign wtb_run = hv_rel_r && lv_rel_r && !wd_disable_r;

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rtb_div_r <= '0;
      end else if (!rtb_run) begin
         rtb_div_r <= '0;
      end else if (rtb_div_r == DIVW'(RESET_TB_DIV - 1)) begin
         rtb_div_r <= '0;
      end else begin
         rtb_div_r <= rtb_div_r + 1'b1;
      end
   end
   assign rtb_tick = rtb_run && (rtb_div_r == DIVW'(RESET_TB_DIV - 1));

   // Watchdog timebase restarts on a valid kick so counts start from zero
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         wtb_div_r <= '0;
      end else if (!wtb_run || (wd_state_r == WD_WATCH && kick_fall)) begin
         wtb_div_r <= '0;
      end else if (wtb_div_r == DIVW'(WATCHDOG_TB_DIV - 1)) begin
         wtb_div_r <= '0;
      end else begin
         wtb_div_r <= wtb_div_r + 1'b1;
      end
   end
   assign wtb_tick = wtb_run && (wtb_div_r == DIVW'(WATCHDOG_TB_DIV - 1));

   // Per-channel reset timeout; losing regulation re-asserts the reset
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         hv_cnt_r <= COUNT_RESET_VALUE;
         hv_rel_r <= 1'b0;
      end else if (!hv_good_r) begin
         hv_cnt_r <= COUNT_RESET_VALUE;
         hv_rel_r <= 1'b0;
      end else if (!hv_rel_r && rtb_tick) begin
         if (hv_cnt_r == 7'(RESET_TIMEOUT_TICKS - 1)) begin
            hv_rel_r <= 1'b1;
         end
         hv_cnt_r <= hv_cnt_r + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         lv_cnt_r <= COUNT_RESET_VALUE;
         lv_rel_r <= 1'b0;
      end else if (!lv_good_r) begin
         lv_cnt_r <= COUNT_RESET_VALUE;
         lv_rel_r <= 1'b0;
      end else if (!lv_rel_r && rtb_tick) begin
         if (lv_cnt_r == 7'(RESET_TIMEOUT_TICKS - 1)) begin
            lv_rel_r <= 1'b1;
         end
         lv_cnt_r <= lv_cnt_r + 7'h01;
      end
   end

   // Watchdog sequence
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         wd_state_r <= WD_OFF;
         wd_cnt_r <= COUNT_RESET_VALUE;
         fault_cnt_r <= COUNT_RESET_VALUE;
      end else if (!wtb_run && wd_state_r != WD_FAULT) begin
         wd_state_r <= WD_OFF;
         wd_cnt_r <= COUNT_RESET_VALUE;
         fault_cnt_r <= COUNT_RESET_VALUE;
      end else begin
         case (wd_state_r)
            WD_OFF: begin
               wd_state_r <= WD_DELAY;
               wd_cnt_r <= COUNT_RESET_VALUE;
            end
            WD_DELAY: begin
               // Kicks are ignored here
               if (wtb_tick) begin
                  if (wd_cnt_r == 7'(KICK_IGNORE_DELAY_TICKS - 1)) begin
                     wd_state_r <= WD_WATCH;
                     wd_cnt_r <= COUNT_RESET_VALUE;
                  end else begin
                     wd_cnt_r <= wd_cnt_r + 7'h01;
                  end
               end
            end
            WD_WATCH: begin
               if (kick_fall) begin
                  if (wd_cnt_r < 7'(WINDOW_LOWER_BOUND_TICKS)) begin
                     wd_state_r <= WD_FAULT;
                     fault_cnt_r <= COUNT_RESET_VALUE;
                  end
                  wd_cnt_r <= COUNT_RESET_VALUE;
               end else if (wtb_tick) begin
                  if (wd_cnt_r == 7'(WINDOW_UPPER_BOUND_TICKS - 1)) begin
                     wd_state_r <= WD_FAULT;
                     fault_cnt_r <= COUNT_RESET_VALUE;
                     wd_cnt_r <= COUNT_RESET_VALUE;
                  end else begin
                     wd_cnt_r <= wd_cnt_r + 7'h01;
                  end
               end
            end
            WD_FAULT: begin
               // Pulse length is the reset timeout, on the reset timebase
               if (rtb_tick) begin
                  if (fault_cnt_r == 7'(RESET_TIMEOUT_TICKS - 1)) begin
                     wd_state_r <= WD_DELAY;
                     wd_cnt_r <= COUNT_RESET_VALUE;
                     fault_cnt_r <= COUNT_RESET_VALUE;
                  end else begin
                     fault_cnt_r <= fault_cnt_r + 7'h01;
                  end
               end
            end
            default: begin
               wd_state_r <= WD_OFF;
            end
         endcase
      end
   end

   // Output flops; open-drain pins only pull low (enable high) or float
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         hv_oe_r <= 1'b1;
         lv_oe_r <= 1'b1;
      end else begin
         hv_oe_r <= !hv_rel_r;
         lv_oe_r <= !lv_rel_r;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         fault_oe_r <= 1'b0;
         all_reg_n_r <= 1'b1;
      end else begin
         fault_oe_r <= (wd_state_r == WD_FAULT);
         all_reg_n_r <= !(hv_good_r && lv_good_r);
      end
   end

   // Pin value flops; never high, so wired-OR of low assertions stays safe
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         hv_pin_r <= 1'b0;
         lv_pin_r <= 1'b0;
         fault_pin_r <= 1'b0;
      end else begin
         hv_pin_r <= 1'b0;
         lv_pin_r <= 1'b0;
         fault_pin_r <= 1'b0;
      end
   end

   assign pins_out.hv_reset_oe = hv_oe_r;
   assign pins_out.lv_reset_oe = lv_oe_r;
   assign pins_out.watchdog_fault_oe = fault_oe_r;
   assign pins_out.all_regulated_n = all_reg_n_r;
   // Output value of each open-drain pin is a constant low
   assign hv_reset_n = hv_pin_r;
   assign lv_reset_n = lv_pin_r;
   assign watchdog_fault_n = fault_pin_r;
endmodule : reset_window_watchdog

// ---- logic/rww_pkg.sv ----
// Shared constants and carriers for the reset sequencer and window watchdog
package rww_pkg;
   localparam int unsigned RESET_TIMEOUT_TICKS = 64;
   localparam int unsigned KICK_IGNORE_DELAY_TICKS = 33;
   localparam int unsigned WINDOW_LOWER_BOUND_TICKS = 4;
   localparam int unsigned WINDOW_UPPER_BOUND_TICKS = 64;
   localparam int unsigned RESET_TB_DIV_DEFAULT = 16;
   localparam int unsigned WATCHDOG_TB_DIV_DEFAULT = 16;
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [6:0] COUNT_RESET_VALUE = 7'h00;

   typedef struct packed {
      logic hv_regulation_good;
      logic lv_regulation_good;
      logic watchdog_kick;
      logic watchdog_enable_n;
   } pin_in_t;

   typedef struct packed {
      logic hv_reset_oe;
      logic lv_reset_oe;
      logic watchdog_fault_oe;
      logic all_regulated_n;
   } pin_out_t;

   typedef enum logic [1:0] {
      WD_OFF,
      WD_DELAY,
      WD_WATCH,
      WD_FAULT
   } wd_state_t;
endpackage : rww_pkg

// ---- tb/kick_source.sv ----
// Processor model issuing periodic falling kick edges
`timescale 1ns/1ps
module kick_source (
   input wire logic clk,
   input wire logic run,
   input wire logic [8:0] gap,
   output logic kick
);
   logic [8:0] cnt_r;
   logic level_r;
   // Idle high like the pulled-up pin; first edge falls as run rises
   assign kick = !run || level_r;
   always_ff @(negedge clk) begin
      if (!run) begin
         cnt_r <= 9'h000;
         level_r <= 1'b0;
      end else begin
         level_r <= (cnt_r + 9'h001 >= {1'b0, gap[8:1]}) && (cnt_r + 9'h001 < gap);
         cnt_r <= (cnt_r + 9'h001 >= gap) ? 9'h000 : cnt_r + 9'h001;
      end
   end
endmodule : kick_source

// ---- tb/rww_chk.sv ----
// Port checks for the reset sequencer and window watchdog
`timescale 1ns/1ps
module rww_chk
   import rww_pkg::*;
#(
   parameter int unsigned RESET_TB_DIV = 1,
   parameter int unsigned WATCHDOG_TB_DIV = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire rww_pkg::pin_in_t pins_in,
   input wire rww_pkg::pin_out_t pins_out,
   input wire logic hv_reset_n,
   input wire logic lv_reset_n,
   input wire logic watchdog_fault_n
);
   logic [15:0] fault_len_r;
   logic [15:0] since_rel_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_len_r <= 16'h0000;
      end else begin
         fault_len_r <= pins_out.watchdog_fault_oe ? fault_len_r + 16'h0001 : 16'h0000;
      end
   end
   // Restarts on each fault too, since a new delay follows every pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         since_rel_r <= 16'h0000;
      end else if (pins_out.lv_reset_oe || pins_out.watchdog_fault_oe) begin
         since_rel_r <= 16'h0000;
      end else if (since_rel_r != 16'hFFFF) begin
         since_rel_r <= since_rel_r + 16'h0001;
      end
   end
   sequence s_disabled;
      pins_in.watchdog_enable_n [*8];
   endsequence
   sequence s_unregulated;
      (!pins_in.hv_regulation_good || !pins_in.lv_regulation_good) [*7];
   endsequence
   a_pins_low_only: assert property (!hv_reset_n && !lv_reset_n && !watchdog_fault_n)
      else $error("open-drain pin value not low");
   a_fault_width: assert property ($fell(pins_out.watchdog_fault_oe) |->
      fault_len_r >= 64 * RESET_TB_DIV && fault_len_r <= 65 * RESET_TB_DIV + 2)
      else $error("fault pulse width wrong");
   a_delay_no_fault: assert property ($rose(pins_out.watchdog_fault_oe) |->
      since_rel_r >= 33 * WATCHDOG_TB_DIV) else $error("fault inside delay");
   a_quiet_in_reset: assert property ((pins_out.hv_reset_oe || pins_out.lv_reset_oe) |->
      !$rose(pins_out.watchdog_fault_oe)) else $error("fault while reset held");
   a_disabled_quiet: assert property (s_disabled |=>
      !$rose(pins_out.watchdog_fault_oe)) else $error("fault while disabled");
   a_lost_regulation: assert property (!pins_in.hv_regulation_good [*7] |=>
      pins_out.hv_reset_oe) else $error("hv reset released without regulation");
   a_regulated_both: assert property (s_unregulated |=> pins_out.all_regulated_n)
      else $error("all regulated low too early");
   a_release_timeout: assert property ($fell(pins_out.lv_reset_oe) |->
      $past(pins_in.lv_regulation_good, 64 * RESET_TB_DIV)) else $error("early release");
endmodule : rww_chk

// ---- tb/tb_reset_window_watchdog.sv ----
// Bench for the reset sequencer and window watchdog
`timescale 1ns/1ps
module tb_reset_window_watchdog;
   import rww_pkg::*;
   localparam int unsigned RESET_TB_DIV = 1;
   localparam int unsigned WATCHDOG_TB_DIV = 4;
   localparam int RST = 64 * RESET_TB_DIV;
   localparam int DLY = 33 * WATCHDOG_TB_DIV;
   localparam int LOW = 4 * WATCHDOG_TB_DIV;
   localparam int UP = 64 * WATCHDOG_TB_DIV;
   logic clk;
   logic arst_n;
   logic hv_good;
   logic lv_good;
   logic en_n;
   logic kick;
   logic kick_run;
   logic [8:0] kick_gap;
   pin_in_t pins_in;
   pin_out_t pins_out;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   assign pins_in = '{hv_good, lv_good, kick, en_n};
   reset_window_watchdog #(.RESET_TB_DIV(RESET_TB_DIV), .WATCHDOG_TB_DIV(WATCHDOG_TB_DIV)) dut (
      .clk(clk), .arst_n(arst_n), .pins_in(pins_in), .pins_out(pins_out),
      .hv_reset_n(), .lv_reset_n(), .watchdog_fault_n());
   kick_source cpu (.clk(clk), .run(kick_run), .gap(kick_gap), .kick(kick));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         close_out();
      end
   end
   task automatic chk_bit(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : chk_bit
   task automatic chk_range(input int got, input int lo, input int hi, input string what);
      check_count++;
      if (got < lo || got > hi) begin
         errors++;
         $display("BAD %0t %s took %0d", $time, what, got);
      end
   endtask : chk_range
   task automatic wait_fault(input logic lvl, input int limit, output int k);
      k = 0;
      while (pins_out.watchdog_fault_oe !== lvl && k < limit) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_fault
   task automatic t_power_up();
      hv_good = 1'b1;
      lv_good = 1'b1;
      repeat (10) @(negedge clk);
      chk_bit(pins_out.all_regulated_n, 1'b0, "regulated");
      n = 10;
      while (pins_out.lv_reset_oe !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk_range(n, RST, RST + 8, "release");
      chk_bit(pins_out.hv_reset_oe, 1'b0, "hv release");
      $display("power-up done");
   endtask : t_power_up
   task automatic t_kicks();
      kick_gap = 9'(LOW / 2);
      kick_run = 1'b1;
      wait_fault(1'b1, 100, n);
      kick_run = 1'b0;
      chk_range(n, 100, 100, "delay kicks");
      repeat (100) @(negedge clk);
      kick_gap = 9'(UP / 4);
      kick_run = 1'b1;
      wait_fault(1'b1, 1500, n);
      chk_range(n, 1500, 1500, "good kicks");
      $display("kicks done");
   endtask : t_kicks
   task automatic t_no_kick();
      kick_run = 1'b0;
      wait_fault(1'b1, UP + 40, n);
      chk_range(n, UP - UP / 4 - 2, UP + 10, "late fault");
      wait_fault(1'b0, 200, n);
      chk_range(n, RST, RST + 2, "fault width");
      wait_fault(1'b1, DLY + UP + 40, n);
      // Free-running divider phase at fault end shifts the first delay tick
      chk_range(n, DLY + UP - WATCHDOG_TB_DIV, DLY + UP + 10, "second fault");
      wait_fault(1'b0, 200, n);
      $display("no-kick done");
   endtask : t_no_kick
   task automatic t_close_kicks();
      repeat (200) @(negedge clk);
      kick_gap = 9'(LOW / 2);
      kick_run = 1'b1;
      wait_fault(1'b1, 40, n);
      chk_range(n, LOW / 2, LOW / 2 + 8, "close kicks");
      kick_run = 1'b0;
      wait_fault(1'b0, 200, n);
      $display("close kicks done");
   endtask : t_close_kicks
   task automatic t_disable();
      en_n = 1'b1;
      wait_fault(1'b1, 600, n);
      chk_range(n, 600, 600, "disabled");
      hv_good = 1'b0;
      repeat (8) @(negedge clk);
      chk_bit(pins_out.hv_reset_oe, 1'b1, "hv reassert");
      chk_bit(pins_out.all_regulated_n, 1'b1, "regulation lost");
      $display("disable done");
   endtask : t_disable
   initial begin
      arst_n = 1'b0;
      hv_good = 1'b0;
      lv_good = 1'b0;
      en_n = 1'b0;
      kick_run = 1'b0;
      kick_gap = 9'h040;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_power_up();
      t_kicks();
      t_no_kick();
      t_close_kicks();
      t_disable();
      close_out();
   end
endmodule : tb_reset_window_watchdog
bind reset_window_watchdog rww_chk #(.RESET_TB_DIV(RESET_TB_DIV),
   .WATCHDOG_TB_DIV(WATCHDOG_TB_DIV)) chk (.clk(clk), .arst_n(arst_n), .pins_in(pins_in),
   .pins_out(pins_out), .hv_reset_n(hv_reset_n), .lv_reset_n(lv_reset_n),
   .watchdog_fault_n(watchdog_fault_n));
